// ### esc_cfg.svh
`ifndef ESC_CFG_SVH
`define ESC_CFG_SVH
// ********************************************************************
// link framing
// ********************************************************************
`define ESC_CMD_BITS      6'h08       // command bits per frame
`define ESC_CNT_CMD_LAST  6'h07       // bit count while last command bit arrives
`define ESC_CNT_DATA0     6'h08       // bit count of first data bit
`define ESC_CNT_DATA_LAST 6'h27       // bit count of 32nd data bit
`define ESC_CNT_END       6'h28       // bit count after the whole frame
`define ESC_CNT_RESET     6'h00       // bit count at frame start
// ********************************************************************
// command byte fields
// ********************************************************************
`define ESC_BIT_SEL_CONT  3'h7        // select_continuous_counter
`define ESC_BIT_SEL_POW   3'h6        // select_powered_counter
`define ESC_BIT_TRIM_HI   3'h5        // trim_bit_high
`define ESC_BIT_TRIM_LO   3'h3        // trim_bit_low
`define ESC_BIT_CLR_CONT  3'h2        // clear_continuous_counter
`define ESC_BIT_CLR_POW   3'h1        // clear_powered_counter
`define ESC_BIT_RD        3'h0        // direction, one means read
// ********************************************************************
// reset values and timebase
// ********************************************************************
`define ESC_CMD_RESET     8'h00
`define ESC_WORD_RESET    32'h0000_0000
`define ESC_WORD_ONE      32'h0000_0001
`define ESC_TRIM_RESET    3'h3        // recommended default trim
`define ESC_TRIM_NOMINAL  3'h3        // trim code giving the nominal rate
`define ESC_TRIM_STOP     3'h0        // trim code that halts the oscillator
`define ESC_OSC_HZ        32'h0000_8000
`define ESC_TICK_HZ       32'h0000_0001
`define ESC_TRIM_STEP     32'h0000_0001
`endif

// ### esc_pkg.sv
// ********************************************************************
// shared types of the elapsed seconds counter port
// ********************************************************************
package esc_pkg;
  typedef logic [31:0] esc_word_t;    // counter and data word
  typedef logic [7:0]  esc_cmd_t;     // command byte
  typedef logic [2:0]  esc_trim_t;    // oscillator trim code
  typedef logic [5:0]  esc_bitcnt_t;  // serial bit count of a frame
endpackage : esc_pkg

// ### esc_tick.sv
`timescale 1ns/1ps
`default_nettype none
`include "esc_cfg.svh"
// ********************************************************************
// one second tick from the trimmed oscillator
// ********************************************************************
module esc_tick #(
  parameter int OSC_DIV   = `ESC_OSC_HZ / `ESC_TICK_HZ,  // oscillator edges per tick
  parameter int TRIM_STEP = `ESC_TRIM_STEP               // edges moved per trim step
) (
  input  wire logic              mclk,
  input  wire logic              rstn,
  input  wire logic              osc_in,
  input  wire esc_pkg::esc_trim_t trim,
  output logic                   tick
);
  import esc_pkg::*;

  // largest terminal count, reached at trim code zero
  localparam int TOP = OSC_DIV - 1 + int'(`ESC_TRIM_NOMINAL) * TRIM_STEP;
  localparam int CW  = $clog2(TOP + 1);

  logic          osc_s1_reg;  // first synchroniser stage
  logic          osc_s2_reg;  // second synchroniser stage
  logic          osc_s3_reg;  // edge history
  logic [CW-1:0] div_reg;     // oscillator edge counter
  logic [CW-1:0] term;        // terminal count for this trim

  // ********************************************************************
  // oscillator pin synchroniser
  // ********************************************************************
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      osc_s1_reg <= 1'b0;
      osc_s2_reg <= 1'b0;
      osc_s3_reg <= 1'b0;
    end else begin
      osc_s1_reg <= osc_in;
      osc_s2_reg <= osc_s1_reg;
      osc_s3_reg <= osc_s2_reg;
    end
  end

  // higher trim gives a shorter period, so seconds run faster
  always_comb begin
    term = CW'(TOP - int'(trim) * TRIM_STEP);
  end

  // ********************************************************************
  // divider, frozen while trim stops the oscillator
  // ********************************************************************
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      div_reg <= '0;
      tick    <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (osc_s2_reg && !osc_s3_reg && trim != `ESC_TRIM_STOP) begin
        if (div_reg >= term) begin
          div_reg <= '0;
          tick    <= 1'b1;
        end else begin
          div_reg <= div_reg + CW'(1);
        end
      end
    end
  end
endmodule : esc_tick
`default_nettype wire

// ### esc_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "esc_cfg.svh"
// Overview of operation
// - port works only while transfer enable high
// - first eight rising edges shift command byte
// - bit 7 targets continuous counter
// - read snapshot shifted out over 32 clocks
// - written word loads counter at 32nd edge
// - bit 6 targets powered counter
// - bits 7 and 6 load trim from 5:3
// - higher trim faster, zero trim halts counting
// - bit 2 clears continuous counter at end
// - bit 1 clears powered counter at end
// - bit 0 selects read, else write
// - read data changes at falling edges
// - enable low aborts and releases data pin
// - low main supply refuses all accesses
// - continuous counter counts while oscillator runs
// - powered counter counts only with supply good
// - drive data only while serial clock low
// - first bit after command; extra clocks ignored
module esc_port #(
  parameter int OSC_DIV   = `ESC_OSC_HZ / `ESC_TICK_HZ,  // oscillator edges per second
  parameter int TRIM_STEP = `ESC_TRIM_STEP               // edges moved per trim step
) (
  input  wire logic mclk,          // system clock
  input  wire logic rstn,          // asynchronous reset, active low
  input  wire logic sclk,          // serial link clock from the host
  input  wire logic xfer_en,       // transfer enable pin, frames the link
  input  wire logic dq_in,         // data pin level
  output logic      dq_out,        // data pin drive value
  output logic      dq_oe,         // data pin output enable, high drives
  input  wire logic osc_in,        // 32.768 kHz oscillator pin
  input  wire logic supply_above_trip_level  // main supply above supply_trip_level
);
  import esc_pkg::*;

  // ********************************************************************
  // declarations, link side
  // ********************************************************************
  logic        link_rst_n;         // link logic reset: system reset or enable low
  esc_bitcnt_t bit_cnt_reg;        // rising edges seen in this frame
  esc_cmd_t    cmd_reg;            // command byte, kept past the frame
  esc_cmd_t    cmd_now;            // command byte including the arriving bit
  logic        cmd_tgl_reg;        // flips when a command completes
  logic        rd_en_reg;          // this frame reads a counter
  logic        wr_en_reg;          // this frame writes a counter
  esc_word_t   read_word_reg;      // snapshot being sent out
  esc_word_t   wbuf_reg;           // incoming write data
  logic        wr_tgl_reg;         // flips when 32 write bits are in
  logic        sup_l1_reg;         // supply level, first link stage
  logic        sup_l2_reg;         // supply level, second link stage
  logic        dq_out_reg;         // falling edge data bit
  logic        oe_reg;             // falling edge drive request
  // ********************************************************************
  // declarations, system side
  // ********************************************************************
  logic        te_s1_reg;          // enable synchroniser stages
  logic        te_s2_reg;
  logic        te_s3_reg;
  logic        ct_s1_reg;          // command toggle synchroniser stages
  logic        ct_s2_reg;
  logic        ct_s3_reg;
  logic        wt_s1_reg;          // write toggle synchroniser stages
  logic        wt_s2_reg;
  logic        wt_s3_reg;
  logic        sup_s1_reg;         // supply synchroniser stages
  logic        sup_s2_reg;
  logic        te_fall;            // enable seen falling
  logic        cmd_new;            // a command has just completed
  logic        wr_new;             // a write word has just completed
  logic        supply_ok;          // main supply good, synchronised
  esc_cmd_t    cmd_seen_reg;       // last completed command, system copy
  logic        armed_reg;          // a command completed in this frame
  logic        armed_now;          // armed, counting a same cycle command
  esc_cmd_t    clr_cmd;            // command that decides the clears
  logic        do_clear_cont;      // clear continuous counter now
  logic        do_clear_pow;       // clear powered counter now
  logic        load_cont;          // load continuous counter now
  logic        load_pow;           // load powered counter now
  esc_trim_t   trim_reg;           // oscillator trim
  esc_word_t   cont_reg;           // continuous seconds count
  esc_word_t   pow_reg;            // powered seconds count
  esc_word_t   hold_cont_reg;      // continuous count held for a frame
  esc_word_t   hold_pow_reg;       // powered count held for a frame
  logic        tick;               // one second tick

  // enable low resets the bit count, direction, snapshot and read-out at once
  assign link_rst_n = rstn & xfer_en;

  // ********************************************************************
  // link side: frame bit counter
  // ********************************************************************
  // saturates so clocks past the frame are ignored
  always_ff @(posedge sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      bit_cnt_reg <= `ESC_CNT_RESET;
    end else if (bit_cnt_reg != `ESC_CNT_END) begin
      bit_cnt_reg <= bit_cnt_reg + 6'h01;
    end
  end

  // supply level brought into the link domain
  always_ff @(posedge sclk or negedge rstn) begin
    if (!rstn) begin
      sup_l1_reg <= 1'b0;
      sup_l2_reg <= 1'b0;
    end else begin
      sup_l1_reg <= supply_above_trip_level;
      sup_l2_reg <= sup_l1_reg;
    end
  end

  // arriving bit enters at the top, so the first bit lands in bit 0
  assign cmd_now = {dq_in, cmd_reg[7:1]};

  // ********************************************************************
  // link side: command byte
  // ********************************************************************
  // not cleared by enable low: the system side still needs it for clears
  always_ff @(posedge sclk or negedge rstn) begin
    if (!rstn) begin
      cmd_reg     <= `ESC_CMD_RESET;
      cmd_tgl_reg <= 1'b0;
    end else if (bit_cnt_reg < `ESC_CMD_BITS) begin
      cmd_reg <= cmd_now;
      // a refused command never reaches the system side
      if (bit_cnt_reg == `ESC_CNT_CMD_LAST && sup_l2_reg) begin
        cmd_tgl_reg <= ~cmd_tgl_reg;
      end
    end
  end

  // ********************************************************************
  // link side: direction and read snapshot
  // ********************************************************************
  // exactly one counter must be selected, else no data phase
  always_ff @(posedge sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      rd_en_reg     <= 1'b0;
      wr_en_reg     <= 1'b0;
      read_word_reg <= `ESC_WORD_RESET;
    end else if (bit_cnt_reg == `ESC_CNT_CMD_LAST && sup_l2_reg) begin
      rd_en_reg <= cmd_now[`ESC_BIT_RD] &
                   (cmd_now[`ESC_BIT_SEL_CONT] ^ cmd_now[`ESC_BIT_SEL_POW]);
      wr_en_reg <= ~cmd_now[`ESC_BIT_RD] &
                   (cmd_now[`ESC_BIT_SEL_CONT] ^ cmd_now[`ESC_BIT_SEL_POW]);
      // held copies stay frozen while enable is high, so they are stable here
      if (cmd_now[`ESC_BIT_SEL_CONT]) begin
        read_word_reg <= hold_cont_reg;
      end else begin
        read_word_reg <= hold_pow_reg;
      end
    end
  end

  // ********************************************************************
  // link side: write data gathering
  // ********************************************************************
  // the toggle flips with bit 32 already in the buffer, which then holds
  always_ff @(posedge sclk or negedge rstn) begin
    if (!rstn) begin
      wbuf_reg   <= `ESC_WORD_RESET;
      wr_tgl_reg <= 1'b0;
    end else if (wr_en_reg && xfer_en && bit_cnt_reg >= `ESC_CNT_DATA0 &&
                 bit_cnt_reg <= `ESC_CNT_DATA_LAST) begin
      wbuf_reg <= {dq_in, wbuf_reg[31:1]};
      if (bit_cnt_reg == `ESC_CNT_DATA_LAST) begin
        wr_tgl_reg <= ~wr_tgl_reg;
      end
    end
  end

  // ********************************************************************
  // link side: read data out at falling edges
  // ********************************************************************
  always_ff @(negedge sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      dq_out_reg <= 1'b0;
      oe_reg     <= 1'b0;
    end else if (rd_en_reg && bit_cnt_reg >= `ESC_CNT_DATA0 &&
                 bit_cnt_reg <= `ESC_CNT_DATA_LAST) begin
      dq_out_reg <= read_word_reg[5'(bit_cnt_reg - `ESC_CNT_DATA0)];
      oe_reg     <= 1'b1;
    end else begin
      oe_reg <= 1'b0;
    end
  end

  // pin released whenever the serial clock is high
  assign dq_out = dq_out_reg;
  assign dq_oe  = oe_reg & ~sclk;

  // ********************************************************************
  // system side: synchronisers
  // ********************************************************************
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      te_s1_reg  <= 1'b0;
      te_s2_reg  <= 1'b0;
      te_s3_reg  <= 1'b0;
      ct_s1_reg  <= 1'b0;
      ct_s2_reg  <= 1'b0;
      ct_s3_reg  <= 1'b0;
      wt_s1_reg  <= 1'b0;
      wt_s2_reg  <= 1'b0;
      wt_s3_reg  <= 1'b0;
      sup_s1_reg <= 1'b0;
      sup_s2_reg <= 1'b0;
    end else begin
      te_s1_reg  <= xfer_en;
      te_s2_reg  <= te_s1_reg;
      te_s3_reg  <= te_s2_reg;
      ct_s1_reg  <= cmd_tgl_reg;
      ct_s2_reg  <= ct_s1_reg;
      ct_s3_reg  <= ct_s2_reg;
      wt_s1_reg  <= wr_tgl_reg;
      wt_s2_reg  <= wt_s1_reg;
      wt_s3_reg  <= wt_s2_reg;
      sup_s1_reg <= supply_above_trip_level;
      sup_s2_reg <= sup_s1_reg;
    end
  end

  assign te_fall   = te_s3_reg & ~te_s2_reg;
  assign cmd_new   = ct_s2_reg ^ ct_s3_reg;
  assign wr_new    = wt_s2_reg ^ wt_s3_reg;
  assign supply_ok = sup_s2_reg;

  // ********************************************************************
  // system side: command tracking
  // ********************************************************************
  // the command byte is still when its toggle arrives, so copying is safe
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cmd_seen_reg <= `ESC_CMD_RESET;
      armed_reg    <= 1'b0;
    end else begin
      if (cmd_new) begin
        cmd_seen_reg <= cmd_reg;
      end
      // enable falling closes the frame, even in the cycle a new command arrives
      if (cmd_new) begin
        armed_reg <= ~te_fall;
      end else if (te_fall) begin
        armed_reg <= 1'b0;
      end
    end
  end

  // enable may fall right behind the last command bit
  assign armed_now = armed_reg | cmd_new;
  assign clr_cmd   = cmd_new ? cmd_reg : cmd_seen_reg;

  // clears only from a command that selects neither counter
  assign do_clear_cont = te_fall & armed_now & supply_ok &
                         ~clr_cmd[`ESC_BIT_SEL_CONT] & ~clr_cmd[`ESC_BIT_SEL_POW] &
                         clr_cmd[`ESC_BIT_CLR_CONT];
  assign do_clear_pow  = te_fall & armed_now & supply_ok &
                         ~clr_cmd[`ESC_BIT_SEL_CONT] & ~clr_cmd[`ESC_BIT_SEL_POW] &
                         clr_cmd[`ESC_BIT_CLR_POW];
  assign load_cont     = wr_new & supply_ok & cmd_seen_reg[`ESC_BIT_SEL_CONT];
  assign load_pow      = wr_new & supply_ok & cmd_seen_reg[`ESC_BIT_SEL_POW];

  // ********************************************************************
  // system side: oscillator trim
  // ********************************************************************
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      trim_reg <= `ESC_TRIM_RESET;
    end else if (cmd_new && supply_ok && cmd_reg[`ESC_BIT_SEL_CONT] &&
                 cmd_reg[`ESC_BIT_SEL_POW]) begin
      trim_reg <= cmd_reg[`ESC_BIT_TRIM_HI:`ESC_BIT_TRIM_LO];
    end
  end

  // timebase divider
  esc_tick #(
    .OSC_DIV   (OSC_DIV),
    .TRIM_STEP (TRIM_STEP)
  ) u_tick (
    .mclk   (mclk),
    .rstn   (rstn),
    .osc_in (osc_in),
    .trim   (trim_reg),
    .tick   (tick)
  );

  // ********************************************************************
  // system side: continuous counter
  // ********************************************************************
  // clear beats load beats tick; a second lost to a load is by intent
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cont_reg <= `ESC_WORD_RESET;
    end else if (do_clear_cont) begin
      cont_reg <= `ESC_WORD_RESET;
    end else if (load_cont) begin
      cont_reg <= wbuf_reg;
    end else if (tick) begin
      cont_reg <= cont_reg + `ESC_WORD_ONE;
    end
  end

  // ********************************************************************
  // system side: powered counter
  // ********************************************************************
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pow_reg <= `ESC_WORD_RESET;
    end else if (do_clear_pow) begin
      pow_reg <= `ESC_WORD_RESET;
    end else if (load_pow) begin
      pow_reg <= wbuf_reg;
    end else if (tick && supply_ok) begin
      pow_reg <= pow_reg + `ESC_WORD_ONE;
    end
  end

  // ********************************************************************
  // system side: held copies for reads
  // ********************************************************************
  // frozen from enable high until enable low, so the link reads a still word
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      hold_cont_reg <= `ESC_WORD_RESET;
      hold_pow_reg  <= `ESC_WORD_RESET;
    end else if (!te_s2_reg) begin
      hold_cont_reg <= cont_reg;
      hold_pow_reg  <= pow_reg;
    end
  end

  // ********************************************************************
  // checks
  // ********************************************************************
  property p_cmd_shift;
    @(posedge sclk) disable iff (!link_rst_n)
      (bit_cnt_reg == `ESC_CNT_CMD_LAST) |=> (cmd_reg[7] == $past(dq_in));
  endproperty
  a_cmd_shift: assert property (p_cmd_shift) else $error("command bit not shifted");

  property p_first_read_bit;
    @(negedge sclk) disable iff (!link_rst_n)
      (rd_en_reg && bit_cnt_reg == `ESC_CNT_DATA0) |=> (oe_reg && dq_out_reg == $past(read_word_reg[0]));
  endproperty
  a_first_read_bit: assert property (p_first_read_bit) else $error("first read bit wrong");

  property p_release_high;
    @(posedge mclk) disable iff (!rstn)
      sclk |-> !dq_oe;
  endproperty
  a_release_high: assert property (p_release_high) else $error("pin driven while clock high");

  property p_abort;
    @(posedge mclk) disable iff (!rstn)
      !xfer_en |-> (!dq_oe && bit_cnt_reg == `ESC_CNT_RESET);
  endproperty
  a_abort: assert property (p_abort) else $error("link active with enable low");

  property p_write_load;
    @(posedge mclk) disable iff (!rstn)
      (wr_new && supply_ok && cmd_seen_reg[`ESC_BIT_SEL_CONT] && !do_clear_cont)
        |=> (cont_reg == $past(wbuf_reg));
  endproperty
  a_write_load: assert property (p_write_load) else $error("write word not loaded");

  property p_trim_load;
    @(posedge mclk) disable iff (!rstn)
      (cmd_new && supply_ok && cmd_reg[`ESC_BIT_SEL_CONT] && cmd_reg[`ESC_BIT_SEL_POW])
        |=> (trim_reg == $past(cmd_reg[`ESC_BIT_TRIM_HI:`ESC_BIT_TRIM_LO]));
  endproperty
  a_trim_load: assert property (p_trim_load) else $error("trim not loaded");

  property p_clear_cont;
    @(posedge mclk) disable iff (!rstn)
      (te_fall && armed_reg && supply_ok && !cmd_seen_reg[`ESC_BIT_SEL_CONT] &&
       !cmd_seen_reg[`ESC_BIT_SEL_POW] && cmd_seen_reg[`ESC_BIT_CLR_CONT] &&
       !cmd_new) |=> (cont_reg == `ESC_WORD_RESET);
  endproperty
  a_clear_cont: assert property (p_clear_cont) else $error("continuous clear missed");

  property p_cont_count;
    @(posedge mclk) disable iff (!rstn)
      (tick && !do_clear_cont && !load_cont) |=> (cont_reg == $past(cont_reg) + `ESC_WORD_ONE);
  endproperty
  a_cont_count: assert property (p_cont_count) else $error("continuous counter missed tick");

  property p_pow_hold;
    @(posedge mclk) disable iff (!rstn)
      (!supply_ok && !do_clear_pow && !load_pow) |=> $stable(pow_reg);
  endproperty
  a_pow_hold: assert property (p_pow_hold) else $error("powered counter moved in backup");

  property p_trim_stop;
    @(posedge mclk) disable iff (!rstn)
      (trim_reg == `ESC_TRIM_STOP) |=> !tick;
  endproperty
  a_trim_stop: assert property (p_trim_stop) else $error("tick with oscillator stopped");
endmodule : esc_port
`default_nettype wire

// ### esc_host.sv
`timescale 1ns/1ps
`default_nettype none
// host model; sclk idles low outside frames, a free pin wanders
module esc_host (
  input  wire logic dq_out,
  input  wire logic dq_oe,
  output logic      dq_in,
  output logic      sclk,
  output logic      xfer_en
);
  import esc_pkg::*;
  logic h_oe = 1'b0;  // host drives the pin
  logic h_d  = 1'b0;  // host drive value
  logic flt  = 1'b0;  // undriven pin pattern, never a stale level
  initial begin
    sclk    = 1'b0;
    xfer_en = 1'b0;
  end
  always #7 flt = ~flt;
  assign dq_in = dq_oe ? dq_out : (h_oe ? h_d : flt);
  // one frame, lsb first; read bits taken late in the low phase
  task automatic xfer(input esc_cmd_t c, input int n, input esc_word_t wd,
                      output esc_word_t rd, output logic drv);
    rd      = 32'h0;
    drv     = 1'b0;
    xfer_en = 1'b1;
    #200;
    for (int i = 0; i < n; i++) begin
      sclk = 1'b0;
      h_oe = (i < 8) || !c[0];
      h_d  = (i < 8) ? c[i] : wd[i-8];
      #15;
      if (i >= 8 && c[0]) begin
        rd[i-8] = dq_in;
        drv     = drv | dq_oe;
      end
      sclk = 1'b1;
      #15;
    end
    xfer_en = 1'b0;
    #15 sclk = 1'b0;
    h_oe = 1'b0;
    #200;
  endtask : xfer
endmodule : esc_host
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g,e) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch at %0t: got %h exp %h", $time, g, e); end end
module tb_top;
  import esc_pkg::*;
  logic mclk = 1'b0, rstn = 1'b0, osc_in = 1'b0, sup = 1'b1;
  logic sclk, xfer_en, dq_in, dq_out, dq_oe, drv;
  int n_errors = 0, checks_done = 0, cyc = 0;
  esc_word_t rd, c0;
  initial forever #20 mclk = ~mclk;
  initial forever #200 osc_in = ~osc_in;  // fast stand-in oscillator
  esc_port #(.OSC_DIV(8), .TRIM_STEP(1)) dut (.mclk(mclk), .rstn(rstn), .sclk(sclk),
    .xfer_en(xfer_en), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .osc_in(osc_in),
    .supply_above_trip_level(sup));
  esc_host host (.dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in), .sclk(sclk),
    .xfer_en(xfer_en));
  // write a word, read it back
  task automatic t_rw(input esc_cmd_t w, input esc_word_t v);
    host.xfer(w, 40, v, rd, drv);
    host.xfer(w | 8'h01, 40, 32'h0, rd, drv);
    `CHK(rd, v)
    `CHK(drv, 1'b1)
  endtask : t_rw
  // counters halted, so every value is exact
  task automatic t_clr();
    host.xfer(8'hc0, 40, 32'hffff_ffff, rd, drv);
    t_rw(8'h80, 32'h8000_0001);
    t_rw(8'h40, 32'h7fff_fffe);
    host.xfer(8'h00, 8, 32'h0, rd, drv);
    host.xfer(8'h02, 8, 32'h0, rd, drv);
    host.xfer(8'h81, 40, 32'h0, rd, drv);
    `CHK(rd, 32'h8000_0001)
    host.xfer(8'h41, 40, 32'h0, rd, drv);
    `CHK(rd, 32'h0)
    host.xfer(8'h04, 8, 32'h0, rd, drv);
    host.xfer(8'h81, 40, 32'h0, rd, drv);
    `CHK(rd, 32'h0)
  endtask : t_clr
  // abort mid read, then accesses with supply low
  task automatic t_abort();
    host.xfer(8'h81, 20, 32'h0, rd, drv);
    `CHK(dq_oe, 1'b0)
    @(negedge mclk) sup = 1'b0;
    host.xfer(8'h80, 40, 32'h1234_5678, rd, drv);
    host.xfer(8'h81, 40, 32'h0, rd, drv);
    `CHK(drv, 1'b0)
    @(negedge mclk) sup = 1'b1;
    host.xfer(8'h81, 40, 32'h0, rd, drv);
    `CHK(rd, 32'h0)
  endtask : t_abort
  // fast trim, supply good a while then low a while: only one counter keeps moving
  task automatic t_run();
    host.xfer(8'hf8, 8, 32'h0, rd, drv);
    #8000;
    @(negedge mclk) sup = 1'b0;
    #30000;
    @(negedge mclk) sup = 1'b1;
    host.xfer(8'hc0, 8, 32'h0, rd, drv);
    host.xfer(8'h81, 40, 32'h0, rd, drv);
    c0 = rd;
    host.xfer(8'h41, 40, 32'h0, rd, drv);
    `CHK(c0 > rd + 32'h0000_000a, 1'b1)
    `CHK(rd > 32'h0000_0003 && rd < 32'h0000_0009, 1'b1)
    host.xfer(8'h06, 8, 32'h0, rd, drv);
    host.xfer(8'h81, 40, 32'h0, rd, drv);
    `CHK(rd, 32'h0)
    host.xfer(8'h41, 40, 32'h0, rd, drv);
    `CHK(rd, 32'h0)
    host.xfer(8'hd8, 8, 32'h0, rd, drv);
  endtask : t_run
  task automatic give_verdict();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (12) @(negedge mclk);
    rstn = 1'b1;
    repeat (4) @(negedge mclk);
    #7;
    t_clr();
    t_abort();
    t_run();
    give_verdict();
  end
  // hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      give_verdict();
    end
  end
endmodule : tb_top
`default_nettype wire
